/* src/swpsr_top.v */
// Purpose: switch partition control/status bank behind AXI4-Lite
// Assumes: all inputs synchronous to REF_CLK, straps stable at reset
// Notes:   one write and one read in flight at a time
//
// Notes on behaviour
// - twelve control and twelve status registers
// - requested state field writable, 0x2 reserved
// - requested state loaded from boot straps
// - inhibit bit blocks upstream link-down hot reset
// - inhibit bit blocks hot reset propagating downstream
// - inhibit leaves link and physical layers alone
// - begun flag set by hardware, write-one clears
// - done flag set by hardware, write-one clears
// - upstream present bit from hardware initialization
// - upstream port number from hardware initialization
// - current state reported, may lag request
// - spare bits 19, 21:20 writable, no effect
`timescale 1ns/1ps
`include "swpsr_defines.vh"

module swpsr_top #(
   parameter NPART = `SWPSR_NPART
) (
   input  wire                 REF_CLK,
   input  wire                 RST_N,
   // axi4-lite slave
   input  wire [11:0]          S_AXI_AWADDR,
   input  wire                 S_AXI_AWVALID,
   output reg                  S_AXI_AWREADY,
   input  wire [31:0]          S_AXI_WDATA,
   input  wire [3:0]           S_AXI_WSTRB,
   input  wire                 S_AXI_WVALID,
   output reg                  S_AXI_WREADY,
   output reg  [1:0]           S_AXI_BRESP,
   output reg                  S_AXI_BVALID,
   input  wire                 S_AXI_BREADY,
   input  wire [11:0]          S_AXI_ARADDR,
   input  wire                 S_AXI_ARVALID,
   output reg                  S_AXI_ARREADY,
   output reg  [31:0]          S_AXI_RDATA,
   output reg  [1:0]           S_AXI_RRESP,
   output reg                  S_AXI_RVALID,
   input  wire                 S_AXI_RREADY,
   // boot configuration straps
   input  wire [2*NPART-1:0]   BOOT_PART_STATE,
   input  wire [3*NPART-1:0]   BOOT_PART_SPARE,
   input  wire [NPART-1:0]     BOOT_US_PRESENT,
   input  wire [4*NPART-1:0]   BOOT_US_PORT_NUM,
   // upstream link status and hot reset controls
   input  wire [NPART-1:0]     US_DL_DOWN,
   output wire [NPART-1:0]     US_HOT_RESET,
   output wire [NPART-1:0]     DS_HOT_RESET,
   output wire [2*NPART-1:0]   PART_STATE,
   output reg                  IRQ
);

   reg                  init_q;
   reg                  aw_got_q;
   reg                  w_got_q;
   reg  [11:0]          awaddr_q;
   reg  [31:0]          wdata_q;
   reg  [3:0]           wstrb_q;
   reg  [2*NPART-1:0]   int_status_q;
   reg  [2*NPART-1:0]   int_enable_q;
   wire                 strap_load;
   wire                 wr_en;
   wire                 w_ctl;
   wire                 w_sts;
   wire [3:0]           w_idx;
   wire                 w_part_ok;
   wire                 w_hit;
   wire [NPART-1:0]     begun_ev;
   wire [NPART-1:0]     done_ev;
   wire [2*NPART-1:0]   int_set;
   wire [2*NPART-1:0]   int_clr;
   wire [32*NPART-1:0]  ctl_img;
   wire [32*NPART-1:0]  sts_img;
   reg  [31:0]          rd_data;
   reg                  rd_hit;
   wire [3:0]           r_idx;
   wire                 r_part_ok;

   ////////////////////////////////////////////////////////////////////////
   // straps are captured on the first edge after reset release
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         init_q <= 1'b0;
      else
         init_q <= 1'b1;
   end

   assign strap_load = ~init_q;

   ////////////////////////////////////////////////////////////////////////
   // write address and data, taken in either order
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_q      <= 1'b1;
            awaddr_q      <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end else if (wr_en) begin
            aw_got_q <= 1'b0;
         end else if (init_q && !aw_got_q && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_q      <= 1'b1;
            wdata_q      <= S_AXI_WDATA;
            wstrb_q      <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end else if (wr_en) begin
            w_got_q <= 1'b0;
         end else if (init_q && !w_got_q && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // write decode
   assign wr_en     = aw_got_q & w_got_q & ~S_AXI_BVALID;
   assign w_idx     = awaddr_q[5:2];
   assign w_part_ok = (w_idx < NPART);
   assign w_ctl     = (awaddr_q[11:6] == `SWPSR_CTL_BASE >> 6) & w_part_ok;
   assign w_sts     = (awaddr_q[11:6] == `SWPSR_STS_BASE >> 6) & w_part_ok;
   assign w_hit     = w_ctl | w_sts
                    | (awaddr_q[11:2] == `SWPSR_INT_ENABLE >> 2)
                    | (awaddr_q[11:2] == `SWPSR_INT_CLEAR >> 2)
                    | (awaddr_q[11:2] == `SWPSR_INT_STATUS >> 2);

   ////////////////////////////////////////////////////////////////////////
   // write response one cycle after both halves are held
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `SWPSR_RESP_OKAY;
      end else if (wr_en) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= w_hit ? `SWPSR_RESP_OKAY : `SWPSR_RESP_DECERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one instance per partition
   genvar gi;
   generate
      for (gi = 0; gi < NPART; gi = gi + 1) begin : g_part
         swpsr_part u_part (
            .clk            (REF_CLK),
            .rst_n          (RST_N),
            .strap_load     (strap_load),
            .strap_state    (BOOT_PART_STATE[2*gi +: 2]),
            .strap_spare    (BOOT_PART_SPARE[3*gi +: 3]),
            .strap_us       (BOOT_US_PRESENT[gi]),
            .strap_us_num   (BOOT_US_PORT_NUM[4*gi +: 4]),
            .ctl_we         (wr_en & w_ctl & (w_idx == gi)),
            .sts_we         (wr_en & w_sts & (w_idx == gi)),
            .wdata          (wdata_q),
            .wstrb          (wstrb_q),
            .dl_down        (US_DL_DOWN[gi]),
            .ctl_rd         (ctl_img[32*gi +: 32]),
            .sts_rd         (sts_img[32*gi +: 32]),
            .begun_pulse_q  (begun_ev[gi]),
            .done_pulse_q   (done_ev[gi]),
            .cur_q          (PART_STATE[2*gi +: 2]),
            .us_hot_reset_q (US_HOT_RESET[gi]),
            .ds_hot_reset_q (DS_HOT_RESET[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: begun events low half, done events high half
   assign int_set = {done_ev, begun_ev};
   assign int_clr = (wr_en && awaddr_q[11:2] == `SWPSR_INT_CLEAR >> 2)
                    ? wdata_q[2*NPART-1:0] : {2*NPART{1'b0}};

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_status_q <= {2*NPART{1'b0}};
         int_enable_q <= {2*NPART{1'b0}};
         IRQ          <= 1'b0;
      end else begin
         int_status_q <= int_set | (int_status_q & ~int_clr);
         if (wr_en && awaddr_q[11:2] == `SWPSR_INT_ENABLE >> 2)
            int_enable_q <= wdata_q[2*NPART-1:0];
         IRQ <= |(int_status_q & int_enable_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read decode
   assign r_idx     = S_AXI_ARADDR[5:2];
   assign r_part_ok = (r_idx < NPART);

   always @* begin
      rd_data = 32'h00000000;
      rd_hit  = 1'b1;
      if (S_AXI_ARADDR[11:6] == `SWPSR_CTL_BASE >> 6 && r_part_ok)
         rd_data = ctl_img[32*r_idx +: 32];
      else if (S_AXI_ARADDR[11:6] == `SWPSR_STS_BASE >> 6 && r_part_ok)
         rd_data = sts_img[32*r_idx +: 32];
      else if (S_AXI_ARADDR[11:2] == `SWPSR_INT_STATUS >> 2)
         rd_data = {{(32-2*NPART){1'b0}}, int_status_q};
      else if (S_AXI_ARADDR[11:2] == `SWPSR_INT_ENABLE >> 2)
         rd_data = {{(32-2*NPART){1'b0}}, int_enable_q};
      else if (S_AXI_ARADDR[11:2] == `SWPSR_INT_CLEAR >> 2)
         rd_data = 32'h00000000;
      else
         rd_hit = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel, data one cycle after the address is taken
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= `SWPSR_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RDATA   <= rd_data;
         S_AXI_RRESP   <= rd_hit ? `SWPSR_RESP_OKAY : `SWPSR_RESP_DECERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end else if (init_q && !S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

endmodule // swpsr_top

/* src/swpsr_defines.vh */
// Purpose: constants for the switch partition state register bank
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz core clock
// Notes:   byte offsets, field positions, reset values, timing counts
`ifndef SWPSR_DEFINES_VH
`define SWPSR_DEFINES_VH

// partition count and clock
`define SWPSR_NPART          12
`define SWPSR_CLK_PERIOD_NS  5

// register byte offsets
`define SWPSR_CTL_BASE       12'h000
`define SWPSR_STS_BASE       12'h040
`define SWPSR_INT_STATUS     12'h080
`define SWPSR_INT_ENABLE     12'h084
`define SWPSR_INT_CLEAR      12'h088

// control register fields
`define SWPSR_CTL_STATE_LSB  0
`define SWPSR_CTL_INHIBIT    2
`define SWPSR_CTL_SPARE0     19
`define SWPSR_CTL_SPARE1_LSB 20
`define SWPSR_INHIBIT_RST    1'b0

// status register fields
`define SWPSR_STS_BEGUN      0
`define SWPSR_STS_DONE       1
`define SWPSR_STS_US         4
`define SWPSR_STS_USNUM_LSB  5
`define SWPSR_STS_CUR_LSB    9
`define SWPSR_FLAG_RST       1'b0

// partition state codes
`define SWPSR_ST_DISABLED    2'h0
`define SWPSR_ST_ACTIVE      2'h1
`define SWPSR_ST_RSVD        2'h2
`define SWPSR_ST_RESET       2'h3

// state change duration
`define SWPSR_TRANS_NS       100
`define SWPSR_TRANS_CYC \
   ((`SWPSR_TRANS_NS + `SWPSR_CLK_PERIOD_NS - 1) / `SWPSR_CLK_PERIOD_NS)

// bus responses
`define SWPSR_RESP_OKAY      2'h0
`define SWPSR_RESP_DECERR    2'h3

`endif

/* src/swpsr_part.v */
// Purpose: control and status state of one switch partition
// Assumes: straps stable when strap_load pulses
// Notes:   state change runs for TRANS_CYC cycles
`timescale 1ns/1ps
`include "swpsr_defines.vh"

module swpsr_part #(
   parameter CNT_W     = 8,
   parameter TRANS_CYC = `SWPSR_TRANS_CYC
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        strap_load,
   input  wire [1:0]  strap_state,
   input  wire [2:0]  strap_spare,
   input  wire        strap_us,
   input  wire [3:0]  strap_us_num,
   input  wire        ctl_we,
   input  wire        sts_we,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        dl_down,
   output wire [31:0] ctl_rd,
   output wire [31:0] sts_rd,
   output reg         begun_pulse_q,
   output reg         done_pulse_q,
   output reg  [1:0]  cur_q,
   output reg         us_hot_reset_q,
   output reg         ds_hot_reset_q
);

   reg [1:0]       req_q;
   reg             inhibit_q;
   reg [2:0]       spare_q;
   reg             us_q;
   reg [3:0]       usnum_q;
   reg             begun_q;
   reg             done_q;
   reg             busy_q;
   reg [1:0]       tgt_q;
   reg [CNT_W-1:0] cnt_q;
   wire            start_w;
   wire            finish_w;
   wire            clr_begun;
   wire            clr_done;

   // change begins when request differs from current and none is running
   assign start_w   = ~busy_q & ~strap_load & (req_q != cur_q);
   assign finish_w  = busy_q & (cnt_q == {CNT_W{1'b0}});
   assign clr_begun = sts_we & wstrb[0] & wdata[`SWPSR_STS_BEGUN];
   assign clr_done  = sts_we & wstrb[0] & wdata[`SWPSR_STS_DONE];

   // register images, reserved bits zero
   assign ctl_rd = {10'h000, spare_q[2:1], spare_q[0], 16'h0000,
                    inhibit_q, req_q};
   assign sts_rd = {21'h000000, cur_q, usnum_q, us_q,
                    2'h0, done_q, begun_q};

   ///////////////////////////////////////////////////////////////////////
   // software fields and hardware-initialized straps
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q     <= `SWPSR_ST_DISABLED;
         inhibit_q <= `SWPSR_INHIBIT_RST;
         spare_q   <= 3'h0;
         us_q      <= 1'b0;
         usnum_q   <= 4'h0;
      end else if (strap_load) begin
         req_q   <= strap_state;
         spare_q <= strap_spare;
         us_q    <= strap_us;
         usnum_q <= strap_us_num;
      end else if (ctl_we) begin
         if (wstrb[0] && wdata[1:0] != `SWPSR_ST_RSVD)
            req_q <= wdata[1:0];
         if (wstrb[0])
            inhibit_q <= wdata[`SWPSR_CTL_INHIBIT];
         if (wstrb[2])
            spare_q <= {wdata[21:20], wdata[`SWPSR_CTL_SPARE0]};
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // state change sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q         <= `SWPSR_ST_DISABLED;
         tgt_q         <= `SWPSR_ST_DISABLED;
         busy_q        <= 1'b0;
         cnt_q         <= {CNT_W{1'b0}};
         begun_pulse_q <= 1'b0;
         done_pulse_q  <= 1'b0;
      end else begin
         begun_pulse_q <= start_w;
         done_pulse_q  <= finish_w;
         if (strap_load) begin
            cur_q <= strap_state;
         end else if (finish_w) begin
            busy_q <= 1'b0;
            cur_q  <= tgt_q;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 1'b1;
         end else if (start_w) begin
            busy_q <= 1'b1;
            tgt_q  <= req_q;
            cnt_q  <= TRANS_CYC[CNT_W-1:0] - 1'b1;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // sticky flags, a set in the clearing cycle wins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         begun_q <= `SWPSR_FLAG_RST;
         done_q  <= `SWPSR_FLAG_RST;
      end else begin
         begun_q <= start_w | (begun_q & ~clr_begun);
         done_q  <= finish_w | (done_q & ~clr_done);
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // link-down hot reset; link layers themselves are never touched
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         us_hot_reset_q <= 1'b0;
         ds_hot_reset_q <= 1'b0;
      end else begin
         us_hot_reset_q <= dl_down & us_q & ~inhibit_q;
         ds_hot_reset_q <= dl_down & us_q & ~inhibit_q;
      end
   end

endmodule // swpsr_part

/* test/swpsr_top_monitor.sv */
// Purpose: bus handshake and hot reset checks on the bank's top ports
// Assumes: single REF_CLK domain, RST_N async active low
// Notes:   attached to swpsr_top by bind at the foot of this file
`timescale 1ns/1ps
`include "swpsr_defines.vh"

module swpsr_mon #(
   parameter NPART = 12
) (
   input logic             REF_CLK,
   input logic             RST_N,
   input logic             S_AXI_AWVALID,
   input logic             S_AXI_AWREADY,
   input logic             S_AXI_WVALID,
   input logic             S_AXI_WREADY,
   input logic             S_AXI_BVALID,
   input logic             S_AXI_BREADY,
   input logic             S_AXI_ARVALID,
   input logic             S_AXI_ARREADY,
   input logic             S_AXI_RVALID,
   input logic             S_AXI_RREADY,
   input logic [31:0]      S_AXI_RDATA,
   input logic [1:0]       S_AXI_RRESP,
   input logic [NPART-1:0] US_DL_DOWN,
   input logic [NPART-1:0] US_HOT_RESET,
   input logic [NPART-1:0] DS_HOT_RESET
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   ////////////////////////////////////////////////////////////////////////
   // handshake steps of a bus transfer
   sequence aw_hs; S_AXI_AWVALID && S_AXI_AWREADY; endsequence
   sequence w_hs;  S_AXI_WVALID && S_AXI_WREADY;   endsequence
   sequence ar_hs; S_AXI_ARVALID && S_AXI_ARREADY; endsequence

   ////////////////////////////////////////////////////////////////////////
   // write and read answers
   b_answer_a: assert property (
      aw_hs and w_hs |-> ##2 S_AXI_BVALID) else $error("no write response");
   aw_block_a: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("new write taken before response");
   b_release_a: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response held after handshake");
   ar_answer_a: assert property (
      ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("no read data");
   r_release_a: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data held after handshake");
   decerr_zero_a: assert property (
      S_AXI_RVALID && S_AXI_RRESP == `SWPSR_RESP_DECERR |-> S_AXI_RDATA == 0)
      else $error("unmapped read returned data");

   ////////////////////////////////////////////////////////////////////////
   // hot reset only follows a link down, upstream and downstream alike
   hot_cause_a: assert property (
      (US_HOT_RESET & ~$past(US_DL_DOWN)) == 0)
      else $error("hot reset without link down");
   hot_pair_a: assert property (
      DS_HOT_RESET == US_HOT_RESET) else $error("downstream hot reset differs");
endmodule // swpsr_mon

bind swpsr_top swpsr_mon #(.NPART(NPART)) u_mon (.*);

/* test/swpsr_top_tb.sv */
// Purpose: self-checking bench for the partition state register bank
// Assumes: straps fixed from time zero, AXI4-Lite master in tasks
// Notes:   link/physical layer side of the inhibit is not visible here
`timescale 1ns/1ps
`include "swpsr_defines.vh"

module swpsr_top_tb;
   localparam N = `SWPSR_NPART;
   logic           clk = 1'b0, rst_n = 1'b0;
   logic [11:0]    awaddr = '0, araddr = '0;
   logic [31:0]    wdata = '0, d;
   logic [3:0]     wstrb = '0;
   logic           awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic           rready = 0;
   logic [2*N-1:0] bst;
   logic [3*N-1:0] bsp;
   logic [4*N-1:0] bpn;
   logic [N-1:0]   bus, dl = '0;
   logic [1:0]     r;
   wire  [1:0]     bresp, rresp;
   wire  [31:0]    rdata;
   wire            awr, wrd, bv, arr, rv, irq;
   wire  [N-1:0]   ush, dsh;
   wire  [2*N-1:0] pst;
   int             failures = 0, checks_done = 0;

   swpsr_top #(.NPART(N)) dut (.REF_CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .BOOT_PART_STATE(bst),
      .BOOT_PART_SPARE(bsp), .BOOT_US_PRESENT(bus), .BOOT_US_PORT_NUM(bpn),
      .US_DL_DOWN(dl), .US_HOT_RESET(ush), .DS_HOT_RESET(dsh),
      .PART_STATE(pst), .IRQ(irq));

   ////////////////////////////////////////////////////////////////////////
   // clock, strap values and expected register images
   always #2.5 clk = ~clk;
   function automatic logic [1:0] st(int i);
      return (i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h1 : 2'h3;
   endfunction
   function automatic logic [31:0] ectl(int i);
      return {10'h0, i[2:0] ^ 3'h5, 16'h0, 1'b0, st(i)};
   endfunction
   function automatic logic [31:0] ests(int i, logic [1:0] c, logic [1:0] f);
      return {21'h0, c, i[3:0] ^ 4'ha, ~i[0], 2'b0, f};
   endfunction
   initial for (int i = 0; i < N; i++) begin
      bst[2*i+:2] = st(i);
      bsp[3*i+:3] = i[2:0] ^ 3'h5;
      bus[i] = ~i[0];
      bpn[4*i+:4] = i[3:0] ^ 4'ha;
   end

   ////////////////////////////////////////////////////////////////////////
   // compare, bus tasks and closing
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] s);
      int n;
      logic aw_t, w_t, b_t;
      n = 0;
      b_t = 1'b0;
      @(posedge clk);
      awaddr <= a; wdata <= v; wstrb <= s;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      // handshakes judged mid-cycle, acted on after the taking edge
      do begin
         @(negedge clk);
         aw_t = awvalid && (awr === 1'b1);
         w_t = wvalid && (wrd === 1'b1);
         b_t = (bv === 1'b1);
         if (b_t) r = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 0;
         if (w_t) wvalid <= 0;
         n++;
      end while (!b_t && n < 100);
      if (!b_t) begin
         failures++;
         $display("CHECK FAILED t=%0t write response timeout", $time);
      end
      bready <= 0;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      logic ar_t, r_t;
      n = 0;
      r_t = 1'b0;
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(negedge clk);
         ar_t = arvalid && (arr === 1'b1);
         r_t = (rv === 1'b1);
         if (r_t) begin
            d = rdata;
            r = rresp;
         end
         @(posedge clk);
         if (ar_t) arvalid <= 0;
         n++;
      end while (!r_t && n < 100);
      if (!r_t) begin
         failures++;
         $display("CHECK FAILED t=%0t read data timeout", $time);
      end
      rready <= 0;
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      for (int i = 0; i < N; i++) begin
         rd(`SWPSR_CTL_BASE + 4 * i); chk(d, ectl(i));
         rd(`SWPSR_STS_BASE + 4 * i);
         chk(d, ests(i, st(i), 2'h0));
      end
      chk(pst, bst);
   endtask
   task automatic t_change;
      wr(`SWPSR_INT_ENABLE, 32'hffffff, 4'hf);
      wr(`SWPSR_CTL_BASE, 32'h1, 4'h1); chk(r, `SWPSR_RESP_OKAY);
      repeat (2) @(posedge clk);
      rd(`SWPSR_STS_BASE); chk(d, ests(0, 2'h0, 2'h1));
      chk(pst[1:0], 2'h0);
      repeat (30) @(posedge clk);
      rd(`SWPSR_STS_BASE); chk(d, ests(0, 2'h1, 2'h3));
      chk(pst[1:0], 2'h1);
      rd(`SWPSR_INT_STATUS); chk(d, 32'h1001);
      chk(irq, 1'b1);
      wr(`SWPSR_INT_ENABLE, 32'h0, 4'hf); repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wr(`SWPSR_INT_ENABLE, 32'hffffff, 4'hf); repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wr(`SWPSR_STS_BASE, 32'h3, 4'h1);
      rd(`SWPSR_STS_BASE); chk(d, ests(0, 2'h1, 2'h0));
      wr(`SWPSR_INT_CLEAR, 32'h1001, 4'hf); repeat (2) @(posedge clk);
      chk(irq, 1'b0);
   endtask
   task automatic t_codes;
      logic [1:0] c [3] = '{2'h0, 2'h1, 2'h3};
      foreach (c[k]) begin
         wr(`SWPSR_CTL_BASE + 8, {30'h0, c[k]}, 4'h1);
         repeat (30) @(posedge clk);
         rd(`SWPSR_CTL_BASE + 8);
         chk(d, (ectl(2) & 32'hfffffffc) | {30'h0, c[k]});
         rd(`SWPSR_STS_BASE + 8); chk(d, ests(2, c[k], 2'h3));
      end
      wr(`SWPSR_CTL_BASE + 8, 32'h0010_0002, 4'h5);
      rd(`SWPSR_CTL_BASE + 8); chk(d, 32'h0010_0003);
   endtask
   task automatic t_hot;
      @(posedge clk); dl <= 12'h030;
      repeat (3) @(posedge clk);
      chk(ush, 12'h010); chk(dsh, 12'h010);
      wr(`SWPSR_CTL_BASE + 16, 32'h5, 4'h1); repeat (3) @(posedge clk);
      chk(ush, 12'h000); chk(dsh, 12'h000);
      rd(`SWPSR_CTL_BASE + 16); chk(d, ectl(4) | 32'h4);
      dl <= 12'h000;
   endtask
   task automatic t_unmapped;
      rd(12'hffc); chk(r, `SWPSR_RESP_DECERR); chk(d, 32'h0);
      wr(12'hffc, 32'hffffffff, 4'hf); chk(r, `SWPSR_RESP_DECERR);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset; t_change; t_codes; t_hot; t_unmapped;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish;
   end
endmodule // swpsr_top_tb
